/* File: core/fqb_cfg.svh */
`ifndef FQB_CFG_SVH
`define FQB_CFG_SVH
// widths of the query port
`define FQB_DATA_W 16
`define FQB_OFS_W 8
// word offsets of the query table
`define FQB_OFS_PRI_P 8'h39
`define FQB_OFS_PRI_R 8'h3a
`define FQB_OFS_PRI_I 8'h3b
`define FQB_OFS_PSC_LO 8'h43
`define FQB_OFS_PSC_HI 8'h44
`define FQB_OFS_VDD_OPT 8'h45
`define FQB_OFS_VPP_OPT 8'h46
`define FQB_OFS_RSVD 8'h47
`define FQB_OFS_PAGE 8'h48
`define FQB_OFS_SYNC_CNT 8'h49
`define FQB_OFS_SYNC1 8'h4a
`define FQB_OFS_SYNC2 8'h4b
`define FQB_OFS_SYNC3 8'h4c
`define FQB_OFS_MAX_CLK 8'h4d
`define FQB_OFS_WAIT 8'h4e
// fixed contents of the query table
`define FQB_VAL_PRI_P 16'h0050
`define FQB_VAL_PRI_R 16'h0052
`define FQB_VAL_PRI_I 16'h0049
`define FQB_VAL_PSC_LO 16'h0003
`define FQB_VAL_PSC_HI 16'h0000
`define FQB_VAL_VDD_OPT 16'h0018
`define FQB_VAL_VPP_OPT 16'h00c0
`define FQB_VAL_RSVD 16'h0000
`define FQB_VAL_PAGE 16'h0003
`define FQB_VAL_SYNC_CNT 16'h0003
`define FQB_VAL_SYNC1 16'h0001
`define FQB_VAL_SYNC2 16'h0002
`define FQB_VAL_SYNC3 16'h0007
`define FQB_VAL_MAX_CLK 16'h0028
`define FQB_VAL_WAIT 16'h0001
`define FQB_VAL_UNMAPPED 16'h0000
// field positions and codes
`define FQB_PSC_PROT_BIT 0
`define FQB_PSC_LOCK_BIT 1
`define FQB_SYNC_CODE_MSB 2
`define FQB_SYNC_CONTINUOUS 3'h7
`define FQB_VOLT_WHOLE_LSB 4
`define FQB_VOLT_TENTHS_MSB 3
`define FQB_BCD_MAX 4'h9
`define FQB_WAIT_SYNC_BIT 0
`define FQB_WAIT_ASYNC_BIT 1
// latency from output enable falling to data on the pins, in cycles
`define FQB_READ_LAT 3
`endif

/* File: core/fqb_pkg.sv */
`include "fqb_cfg.svh"
package fqb_pkg;
  // read sequencer states, gray along idle -> address -> read
  typedef enum logic [1:0] {
    fqb_idle = 2'b00,
    fqb_addr = 2'b01,
    fqb_read = 2'b11
  } fqb_state_e;
  // whole state of the query port
  typedef struct packed {
    fqb_state_e state;
    logic [`FQB_OFS_W-1:0] ofs;
    logic [`FQB_DATA_W-1:0] data;
    logic busy;
  } fqb_port_s;
endpackage

/* File: core/fqb_sync2.sv */
`timescale 1ns/10ps
module fqb_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // two flops per bit; the first is read only by the second
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } fqb_sync_s;
  fqb_sync_s st;
  fqb_sync_s next_st;
  // shift the pin level through both stages
  always_comb begin
    next_st.meta = d;
    next_st.safe = st.meta;
  end
  // async reset to the idle level of the pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= {INIT, INIT};
    end else begin
      st <= next_st;
    end
  end
  assign q = st.safe;
endmodule // fqb_sync2

/* File: core/fqb_rom.sv */
`timescale 1ns/10ps
`include "fqb_cfg.svh"
module fqb_rom (
  input wire logic [`FQB_OFS_W-1:0] ofs,
  output logic [`FQB_DATA_W-1:0] word,
  output logic hit
);
  // constant lookup of the query words
  always_comb begin
    hit = 1'b1;
    unique case (ofs)
      `FQB_OFS_PRI_P: word = `FQB_VAL_PRI_P;
      `FQB_OFS_PRI_R: word = `FQB_VAL_PRI_R;
      `FQB_OFS_PRI_I: word = `FQB_VAL_PRI_I;
      `FQB_OFS_PSC_LO: word = `FQB_VAL_PSC_LO;
      `FQB_OFS_PSC_HI: word = `FQB_VAL_PSC_HI;
      `FQB_OFS_VDD_OPT: word = `FQB_VAL_VDD_OPT;
      `FQB_OFS_VPP_OPT: word = `FQB_VAL_VPP_OPT;
      `FQB_OFS_RSVD: word = `FQB_VAL_RSVD;
      `FQB_OFS_PAGE: word = `FQB_VAL_PAGE;
      `FQB_OFS_SYNC_CNT: word = `FQB_VAL_SYNC_CNT;
      `FQB_OFS_SYNC1: word = `FQB_VAL_SYNC1;
      `FQB_OFS_SYNC2: word = `FQB_VAL_SYNC2;
      `FQB_OFS_SYNC3: word = `FQB_VAL_SYNC3;
      `FQB_OFS_MAX_CLK: word = `FQB_VAL_MAX_CLK;
      `FQB_OFS_WAIT: word = `FQB_VAL_WAIT;
      default: begin
        // outside this part of the table
        word = `FQB_VAL_UNMAPPED;
        hit = 1'b0;
      end
    endcase
  end
endmodule // fqb_rom

/* File: core/fqb_query_bank.sv */
`timescale 1ns/10ps
`include "fqb_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - word 43h reads 0003h, next word 0000h
// - protect capability bits 0,1 set, rest zero
// - supply words read 0018h at 45h, 00c0h at 46h
// - voltage words: hex volts, bcd tenths
// - word 48h reads 0003h, page size code
// - word 49h reads 0003h, config field count
// - word 4ah reads 0001h, bits 7..3 clear
// - code 07h means continuous linear burst
// - word 4bh reads 0002h, 4ch reads 0007h
// - word 4dh reads 0028h, clock in megahertz
// - word 4eh reads 0001h, wait in sync only
// - extended table base 39h holds p, r, i
module fqb_query_bank
  import fqb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic query_mode,
  input wire logic sync_mode,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic adv_n,
  input wire logic [`FQB_DATA_W-1:0] adq_in,
  output logic [`FQB_DATA_W-1:0] adq_out,
  output logic adq_oe,
  output logic wait_out,
  output logic wait_oe
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // control pins idle high, so they reset high
  localparam logic [3:0] CTL_IDLE = 4'hf;

  // synchronised chip enable, output enable, write enable, latch enable
  logic [3:0] ctl_sync;
  // synchronised multiplexed address/data bus
  logic [`FQB_DATA_W-1:0] adq_sync;
  // decoded control levels, active high
  logic chip_on;
  logic out_on;
  logic write_on;
  logic latch_on;

  // control strobes pass two flops before use
  fqb_sync2 #(
    .W(4),
    .INIT(CTL_IDLE)
  ) u_ctl_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({ce_n, oe_n, we_n, adv_n}),
    .q(ctl_sync)
  );

  // address bits pass two flops before the latch looks at them; the host
  // holds the address steady while the latch is open, so a word caught
  // mid-change is overwritten before the latch closes
  fqb_sync2 #(
    .W(`FQB_DATA_W),
    .INIT('0)
  ) u_adq_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(adq_in),
    .q(adq_sync)
  );

  // turn the active low strobes into active high levels
  assign chip_on = !ctl_sync[3];
  assign out_on = !ctl_sync[2];
  assign write_on = !ctl_sync[1];
  assign latch_on = !ctl_sync[0];

  //////////////////////////////////////////////////////////////////////////////
  // query table lookup

  // registered state of the port
  fqb_port_s st;
  // next value of the port state
  fqb_port_s next_st;
  // word addressed by the latched offset
  logic [`FQB_DATA_W-1:0] rom_word;
  // offset falls inside this part of the table
  logic rom_hit;

  // constant table, no storage, so writes cannot alter it
  fqb_rom u_rom (
    .ofs(st.ofs),
    .word(rom_word),
    .hit(rom_hit)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read sequencer

  // every pin is seen two edges late, so a read answers three edges after
  // the output enable falls; the address latch lags by the same two edges,
  // which keeps the offset and the strobes lined up without extra logic
  // a read may be served: chip on, output on, no write, query mode
  logic read_ok;

  assign read_ok = chip_on && out_on && !write_on && query_mode;

  // next state of the sequencer
  always_comb begin
    next_st = st;
    unique case (st.state)
      fqb_idle: begin
        // wait for the chip to be selected with the latch open
        next_st.busy = 1'b1;
        if (chip_on && latch_on) begin
          next_st.ofs = adq_sync[`FQB_OFS_W-1:0];
          next_st.state = fqb_addr;
        end
      end
      fqb_addr: begin
        next_st.busy = 1'b1;
        if (!chip_on) begin
          // deselect drops the cycle
          next_st.state = fqb_idle;
        end else if (latch_on) begin
          // latch stays transparent while it is open
          next_st.ofs = adq_sync[`FQB_OFS_W-1:0];
        end else if (read_ok) begin
          // capture the table word and start driving
          next_st.data = rom_word;
          next_st.busy = 1'b0;
          next_st.state = fqb_read;
        end else begin
          // a write cycle is swallowed here, the table never changes
          next_st.state = fqb_addr;
        end
      end
      fqb_read: begin
        next_st.busy = 1'b0;
        if (!chip_on) begin
          // deselect ends the read
          next_st.state = fqb_idle;
          next_st.busy = 1'b1;
        end else if (latch_on) begin
          // a new address starts a new access
          next_st.ofs = adq_sync[`FQB_OFS_W-1:0];
          next_st.state = fqb_addr;
          next_st.busy = 1'b1;
        end else if (!read_ok) begin
          // output disabled or write seen: release the bus
          next_st.state = fqb_addr;
          next_st.busy = 1'b1;
        end
      end
      default: begin
        // illegal code, recover to idle
        next_st.state = fqb_idle;
        next_st.busy = 1'b1;
      end
    endcase
  end

  // one register for the whole port state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{state: fqb_idle, ofs: '0, data: '0, busy: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // data comes straight from the captured word
  assign adq_out = st.data;
  // bus is driven only while a read is being served
  assign adq_oe = (st.state == fqb_read);
  // wait shows not ready until data is on the bus
  assign wait_out = st.busy;
  // wait pin is driven in synchronous reads only
  assign wait_oe = adq_oe && sync_mode;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // all checks run on the port clock; they watch the pins, the latched offset and the table decode

  // word at 43h
  psc_low_word_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(adq_oe) && st.ofs == `FQB_OFS_PSC_LO |-> adq_out == `FQB_VAL_PSC_LO
  ) else $error("protect capability low word wrong");

  // word after 43h
  psc_high_word_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && st.ofs == `FQB_OFS_PSC_HI |-> adq_out == `FQB_VAL_PSC_HI
  ) else $error("protect capability high word wrong");

  // both status bits present, upper bits zero
  psc_bit_layout_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && st.ofs == `FQB_OFS_PSC_LO |->
      adq_out[`FQB_PSC_PROT_BIT] && adq_out[`FQB_PSC_LOCK_BIT]
      && adq_out[`FQB_DATA_W-1:`FQB_PSC_LOCK_BIT+1] == '0
  ) else $error("protect capability bits wrong");

  // supply voltage words
  supply_words_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe |->
      (st.ofs != `FQB_OFS_VDD_OPT || adq_out == `FQB_VAL_VDD_OPT)
      && (st.ofs != `FQB_OFS_VPP_OPT || adq_out == `FQB_VAL_VPP_OPT)
  ) else $error("supply voltage word wrong");

  // tenths nibble is a bcd digit
  volt_bcd_nibble_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && (st.ofs == `FQB_OFS_VDD_OPT || st.ofs == `FQB_OFS_VPP_OPT) |->
      adq_out[`FQB_VOLT_TENTHS_MSB:0] <= `FQB_BCD_MAX
  ) else $error("voltage tenths not bcd");

  // page size code
  page_code_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && st.ofs == `FQB_OFS_PAGE |-> adq_out == `FQB_VAL_PAGE
  ) else $error("page capability word wrong");

  // number of burst configuration fields
  sync_count_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && st.ofs == `FQB_OFS_SYNC_CNT |-> adq_out == `FQB_VAL_SYNC_CNT
  ) else $error("burst field count wrong");

  // first burst field, reserved bits clear
  sync_first_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && st.ofs == `FQB_OFS_SYNC1 |->
      adq_out == `FQB_VAL_SYNC1 && adq_out[7:`FQB_SYNC_CODE_MSB+1] == '0
  ) else $error("first burst field wrong");

  // third burst field, continuous code
  sync_rest_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && st.ofs == `FQB_OFS_SYNC3 |->
      adq_out[`FQB_SYNC_CODE_MSB:0] == `FQB_SYNC_CONTINUOUS
      && adq_out == `FQB_VAL_SYNC3
  ) else $error("third burst field wrong");

  // second burst field
  sync_second_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && st.ofs == `FQB_OFS_SYNC2 |-> adq_out == `FQB_VAL_SYNC2
  ) else $error("second burst field wrong");

  // maximum clock
  max_clock_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && st.ofs == `FQB_OFS_MAX_CLK |-> adq_out == `FQB_VAL_MAX_CLK
  ) else $error("max clock word wrong");

  // wait word and wait pin drive
  wait_support_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (adq_oe && st.ofs == `FQB_OFS_WAIT |->
      adq_out[`FQB_WAIT_SYNC_BIT] && !adq_out[`FQB_WAIT_ASYNC_BIT])
    and (wait_oe |-> sync_mode && adq_oe && !wait_out)
  ) else $error("wait support wrong");

  // extended table signature
  pri_string_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe |->
      (st.ofs != `FQB_OFS_PRI_P || adq_out == `FQB_VAL_PRI_P)
      && (st.ofs != `FQB_OFS_PRI_R || adq_out == `FQB_VAL_PRI_R)
      && (st.ofs != `FQB_OFS_PRI_I || adq_out == `FQB_VAL_PRI_I)
  ) else $error("extended table signature wrong");

  // reserved word zero, and a write never drives the bus
  write_ignored_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (adq_oe && st.ofs == `FQB_OFS_RSVD |-> adq_out == `FQB_VAL_RSVD)
    and (write_on |=> !adq_oe)
  ) else $error("reserved word or write handling wrong");

  // a clean read drives data within the fixed latency
  read_latency_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(oe_n) && !ce_n && we_n && adv_n && query_mode && st.state == fqb_addr
      ##1 (!oe_n && !ce_n && we_n && adv_n && query_mode) [*3]
      |-> adq_oe
  ) else $error("read data not driven in time");

  // unmapped offsets read as zero
  unmapped_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe && !rom_hit |-> adq_out == `FQB_VAL_UNMAPPED
  ) else $error("unmapped offset not zero");

  // leaving query mode takes the bus away
  query_gate_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !query_mode |=> !adq_oe
  ) else $error("bus driven outside query mode");

  // deselect releases the bus
  deselect_release_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !chip_on |=> !adq_oe
  ) else $error("bus driven after deselect");

  // open latch follows the synchronised address
  latch_track_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    chip_on && latch_on |=> st.ofs == $past(adq_sync[`FQB_OFS_W-1:0])
  ) else $error("latched offset wrong");

  // driven word holds while the read lasts
  data_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    adq_oe ##1 adq_oe |-> $stable(adq_out)
  ) else $error("driven word changed");

  // only the table words are mapped
  table_hit_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rom_hit == ((st.ofs >= `FQB_OFS_PRI_P && st.ofs <= `FQB_OFS_PRI_I)
      || (st.ofs >= `FQB_OFS_PSC_LO && st.ofs <= `FQB_OFS_WAIT))
  ) else $error("table decode wrong");

  // wait drops to ready as the data appears
  wait_ready_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(adq_oe) |-> $fell(wait_out)
  ) else $error("wait not ready with data");

endmodule // fqb_query_bank

/* File: testbench/fqb_host_model.sv */
`timescale 1ns/10ps
`include "fqb_cfg.svh"
// host side of the query port: drives the pins, puts the inverse of its last value on the bus when released
module fqb_host_model
  import fqb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [`FQB_DATA_W-1:0] adq_out,
  input wire logic adq_oe,
  input wire logic wait_out,
  input wire logic wait_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic adv_n,
  output logic [`FQB_DATA_W-1:0] adq_in
);
  logic [`FQB_DATA_W-1:0] drv; // last value the host put on the bus
  logic host_oe; // host drives the bus
  logic [2:0] read_cfg; // burst field copied by the host
  // all pins idle, bus released
  initial begin
    {ce_n, oe_n, we_n, adv_n, host_oe} = 5'h1e;
    drv = '0;
    read_cfg = '0;
  end
  // wire level: device first, else host, else inverse of the last host value
  assign adq_in = adq_oe ? adq_out : (host_oe ? drv : ~drv);
  ////////////////////////////////////////////////////////////////////////////////
  // voltage word in 100 mv units: hex volts, bcd tenths
  function automatic int volts_dv(input logic [15:0] w);
    return w[7:4] * 10 + w[3:0];
  endfunction
  // burst length in words, 0 for continuous linear burst
  function automatic int burst_len(input logic [2:0] c);
    return (c == `FQB_SYNC_CONTINUOUS) ? 0 : 2 ** (int'(c) + 1);
  endfunction
  // address phase, chip enabled and latch open for three edges
  task automatic latch(input logic [15:0] a);
    @(posedge ref_clk);
    ce_n <= 1'b0;
    adv_n <= 1'b0;
    drv <= a;
    host_oe <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  // one query read; lat stays 0 when the device never drives
  task automatic read_word(input logic [7:0] ofs, output logic [15:0] d,
                           output logic [1:0] wt, output int lat, output int fall);
    latch({~ofs, ofs});
    adv_n <= 1'b1;
    oe_n <= 1'b0;
    host_oe <= 1'b0;
    lat = 0;
    fall = 0;
    d = '0;
    wt = '0;
    for (int n = 1; n <= 8 && lat == 0; n++) begin
      @(posedge ref_clk);
      #1;
      if (adq_oe === 1'b1) begin
        lat = n;
        d = adq_out;
        wt = {wait_oe, wait_out};
      end
    end
    if (ofs == `FQB_OFS_SYNC1) read_cfg = d[2:0];
    @(posedge ref_clk);
    oe_n <= 1'b1;
    ce_n <= 1'b1;
    for (int n = 1; n <= 8 && fall == 0; n++) begin
      @(posedge ref_clk);
      #1;
      if (adq_oe !== 1'b1) fall = n;
    end
  endtask
  // write cycle; counts cycles in which the device drives the bus
  task automatic write_word(input logic [7:0] ofs, input logic [15:0] v, output int drove);
    latch({8'h00, ofs});
    adv_n <= 1'b1;
    we_n <= 1'b0;
    drv <= v;
    drove = 0;
    repeat (6) begin
      @(posedge ref_clk);
      #1;
      if (adq_oe === 1'b1) drove++;
    end
    @(posedge ref_clk);
    we_n <= 1'b1;
    ce_n <= 1'b1;
    host_oe <= 1'b0;
  endtask
endmodule // fqb_host_model

/* File: testbench/tb.sv */
`timescale 1ns/10ps
`include "fqb_cfg.svh"
module tb;
  import fqb_pkg::*;
  logic ref_clk, rst_n, query_mode, sync_mode; // bench driven inputs
  logic ce_n, oe_n, we_n, adv_n, adq_oe, wait_out, wait_oe; // pins
  logic [15:0] adq_in, adq_out, d;
  logic [1:0] wt; // wait enable and level seen with the data
  logic [15:0] seen [0:255]; // words read back, by offset
  int error_cnt, tests_run, cyc, lat, fall, drove;
  // offset and expected word; 42h and 4fh lie outside the table
  logic [23:0] tbl [0:16] = '{24'h39_0050, 24'h3a_0052, 24'h3b_0049, 24'h42_0000,
    24'h43_0003, 24'h44_0000, 24'h45_0018, 24'h46_00c0, 24'h47_0000, 24'h48_0003,
    24'h49_0003, 24'h4a_0001, 24'h4b_0002, 24'h4c_0007, 24'h4d_0028, 24'h4e_0001,
    24'h4f_0000};
  fqb_query_bank fqb_query_bank_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .query_mode(query_mode), .sync_mode(sync_mode), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .adv_n(adv_n), .adq_in(adq_in), .adq_out(adq_out), .adq_oe(adq_oe),
    .wait_out(wait_out), .wait_oe(wait_oe));
  fqb_host_model fqb_host_model_i (.ref_clk(ref_clk), .adq_out(adq_out),
    .adq_oe(adq_oe), .wait_out(wait_out), .wait_oe(wait_oe), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .adv_n(adv_n), .adq_in(adq_in));
  // 50 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %0h, expected %0h", $time, what, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic give_verdict();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // reset held 11 cycles, outputs checked while held
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk({adq_out, adq_oe, wait_out, wait_oe}, {16'h0, 3'b010}, "reset outputs");
    @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  // hang guard, run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    query_mode = 1'b0;
    sync_mode = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    do_reset();
    query_mode <= 1'b1;
    // every word, asynchronous then synchronous read mode
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      sync_mode <= m[0];
      foreach (tbl[i]) begin
        fqb_host_model_i.read_word(tbl[i][23:16], d, wt, lat, fall);
        seen[tbl[i][23:16]] = d;
        chk(d, tbl[i][15:0], "query word");
        chk(lat, `FQB_READ_LAT, "read latency");
        chk(fall, 3, "bus release");
        chk(wt, {m[0], 1'b0}, "wait pin");
      end
    end
    // decoded fields
    chk(seen[8'h43][1:0], 2'b11, "protect bits");
    chk(fqb_host_model_i.volts_dv(seen[8'h45]), 18, "logic supply");
    chk(fqb_host_model_i.volts_dv(seen[8'h46]), 120, "program supply");
    chk(1 << seen[8'h48][7:0], 8, "page bytes");
    chk(seen[8'h49][7:0], 8'h03, "config fields");
    chk(seen[8'h4a][7:3], 5'h0, "reserved bits");
    chk(fqb_host_model_i.burst_len(seen[8'h4a][2:0]), 4, "burst one");
    chk(fqb_host_model_i.burst_len(seen[8'h4b][2:0]), 8, "burst two");
    chk(fqb_host_model_i.burst_len(seen[8'h4c][2:0]), 0, "continuous");
    chk(fqb_host_model_i.read_cfg, 3'h1, "copied field");
    chk(seen[8'h4d], 40, "clock mhz");
    chk(seen[8'h4e][1:0], 2'b01, "handshake bits");
    // writes leave the table alone and never turn the bus round
    for (int k = 0; k < 2; k++) begin
      fqb_host_model_i.write_word(k ? 8'h47 : 8'h45, 16'h5aff, drove);
      chk(drove, 0, "drive on write");
      fqb_host_model_i.read_word(k ? 8'h47 : 8'h45, d, wt, lat, fall);
      chk(d, k ? 16'h0000 : 16'h0018, "after write");
    end
    // no drive outside query mode
    @(posedge ref_clk);
    query_mode <= 1'b0;
    fqb_host_model_i.read_word(8'h43, d, wt, lat, fall);
    chk(lat, 0, "drive outside query");
    @(posedge ref_clk);
    query_mode <= 1'b1;
    // second reset in mid-run, then reads work again
    do_reset();
    fqb_host_model_i.read_word(8'h4d, d, wt, lat, fall);
    chk({d, lat[3:0]}, {16'h0028, 4'h3}, "read after reset");
    give_verdict();
  end
endmodule // tb
